// [hdl/mrat_dev.sv]
// Memory end: decodes mode register commands, holds the registers and returns readback bursts.
`timescale 1ns/1ns
module mrat_dev
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  mrat_if.dev mem,
  output logic banks_active,
  output logic mrw_done,
  output logic [mrat_pkg::MA_W-1:0] mrw_addr,
  output logic [mrat_pkg::OP_W-1:0] mrw_data
);
  import mrat_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_MRR_ADDR, D_MRW_ADDR, D_MRW_LO, D_MRW_HI} mrat_dst_t;

  mrat_dst_t state_q;
  logic [OP_W-1:0] mr_q [MR_N];
  logic [MA_W-1:0] addr_q;
  logic [CA_W-1:0] lo_q;
  logic banks_q;
  logic done_q;
  logic [OP_W-1:0] wdata_q;
  logic pv_q [MRR_PIPE];
  logic [OP_W-1:0] pd_q [MRR_PIPE];
  logic oe_q;
  logic dqs_q;
  logic [OP_W-1:0] dq_q;
  logic [OP_W-1:0] byte_q;
  logic [3:0] bidx_q;

  // (R07) capture needs cke
  wire live = ce && mem.cke;
  wire cmd_beat = live && mem.cs;
  wire data_beat = live && !mem.cs;
  // (R18) six-bit register select
  wire mrr_take = data_beat && state_q == D_MRR_ADDR;
  wire [OP_W-1:0] mrr_byte = mr_q[mem.ca];
  wire [OP_W-1:0] wr_byte = {mem.ca[1:0], lo_q};
  wire wr_take = data_beat && state_q == D_MRW_HI;
  // (R09) read-only writes dropped
  wire wr_ok = wr_take && !MR_RO_MASK[addr_q];
  wire burst_start = ce && pv_q[MRR_PIPE-1];
  wire burst_last = bidx_q == 4'(BL_HALF - 1);
  wire [3:0] bidx_nx = bidx_q + 4'h1;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_q <= D_IDLE;
    else if (ce && !mem.cke)
      state_q <= D_IDLE;
    else if (cmd_beat)
      state_q <= (mem.ca == CMD_MRR) ? D_MRR_ADDR : (mem.ca == CMD_MRW) ? D_MRW_ADDR : D_IDLE;
    else if (data_beat)
    begin
      case (state_q)
        D_MRW_ADDR: state_q <= D_MRW_LO;
        D_MRW_LO: state_q <= D_MRW_HI;
        default: state_q <= D_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      lo_q <= '0;
    end
    else if (data_beat && state_q == D_MRW_ADDR)
      addr_q <= mem.ca;
    else if (data_beat && state_q == D_MRW_LO)
      lo_q <= mem.ca;
  end

  // (R10) bank state only from activate and precharge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      banks_q <= 1'b0;
    else if (cmd_beat && mem.ca == CMD_ACT)
      banks_q <= 1'b1;
    else if (cmd_beat && mem.ca == CMD_PRE)
      banks_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      done_q <= 1'b0;
      wdata_q <= '0;
    end
    else if (ce)
    begin
      done_q <= wr_ok;
      if (wr_ok)
        wdata_q <= wr_byte;
    end
  end

  for (genvar r = 0; r < MR_N; r++)
  begin : g_mr
    always_ff @(posedge clock)
    begin
      if (!rst_n)
        mr_q[r] <= MR_RESET;
      else if (wr_ok && addr_q == MA_W'(r))
        mr_q[r] <= wr_byte;
    end
  end

  // (R11) readback leaves banks alone
  for (genvar s = 0; s < MRR_PIPE; s++)
  begin : g_pipe
    if (s == 0)
    begin : g_head
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          pv_q[s] <= 1'b0;
          pd_q[s] <= '0;
        end
        else if (ce)
        begin
          pv_q[s] <= mrr_take;
          pd_q[s] <= mrr_byte;
        end
      end
    end
    else
    begin : g_body
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          pv_q[s] <= 1'b0;
          pd_q[s] <= '0;
        end
        else if (ce)
        begin
          pv_q[s] <= pv_q[s-1];
          pd_q[s] <= pd_q[s-1];
        end
      end
    end
  end

  // (R01) fixed sixteen-beat burst
  // (R17) byte held first four beats
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      oe_q <= 1'b0;
      dqs_q <= 1'b0;
      dq_q <= '0;
      byte_q <= '0;
      bidx_q <= '0;
    end
    else if (burst_start)
    begin
      oe_q <= 1'b1;
      dqs_q <= 1'b1;
      dq_q <= pd_q[MRR_PIPE-1];
      byte_q <= pd_q[MRR_PIPE-1];
      bidx_q <= '0;
    end
    else if (ce && oe_q)
    begin
      oe_q <= !burst_last;
      dqs_q <= burst_last ? 1'b0 : !dqs_q;
      dq_q <= (!burst_last && bidx_nx < 4'(MRR_HOLD_NCK)) ? byte_q : '0;
      bidx_q <= bidx_nx;
    end
  end

  assign mem.dq_o = dq_q;
  assign mem.dq_oe = oe_q;
  assign mem.dqs_o = dqs_q;
  assign banks_active = banks_q;
  assign mrw_done = done_q;
  assign mrw_addr = addr_q;
  assign mrw_data = wdata_q;
endmodule

// [hdl/mrat_pkg.sv]
// Shared constants, command codes and timing counts for the mode register access link.
package mrat_pkg;

  localparam int MA_W = 6;
  localparam int OP_W = 8;
  localparam int CA_W = 6;
  localparam int MR_N = 64;
  localparam int GAP_W = 8;

  // Command codes carried on the command/address lines in the cycle with chip select high.
  localparam logic [CA_W-1:0] CMD_MRR = 6'h0E;
  localparam logic [CA_W-1:0] CMD_MRW = 6'h06;
  localparam logic [CA_W-1:0] CMD_ACT = 6'h01;
  localparam logic [CA_W-1:0] CMD_PRE = 6'h10;
  localparam logic [CA_W-1:0] CMD_RD = 6'h02;
  localparam logic [CA_W-1:0] CMD_WR = 6'h04;
  localparam logic [CA_W-1:0] CMD_OTHER = 6'h20;

  // Read-only mode registers; writes to them are dropped.
  localparam logic [MR_N-1:0] MR_RO_MASK = 64'h0000_0000_0000_01F1;
  localparam logic [OP_W-1:0] MR_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_RD, OP_RDA, OP_RDF, OP_RDC, OP_WR, OP_WRA, OP_MWR, OP_MWRA, OP_WRF,
    OP_MRR, OP_MRW, OP_ACT, OP_PRE, OP_PDE, OP_PDX
  } mrat_op_t;

  // Clock and latency settings.
  localparam int T_CK_PS = 10000;
  localparam int RL_NCK = 14;
  localparam int WL_NCK = 8;
  localparam int MRR_BL = 16;
  localparam int BL_HALF = MRR_BL / 2;
  localparam int MRR_HOLD_NCK = 2;
  localparam int WPRE_NCK = 2;
  localparam int NRTP_NCK = 8;
  localparam int NWR_NCK = 6;
  localparam int MRR_NCK = 8;
  localparam int MRW_FLOOR_NCK = 8;
  localparam int RTP_BASE_NCK = 8;
  localparam int MRR_MRW_EXTRA_NCK = 3;
  localparam int WR_EXTRA_NCK = 1;

  // Times in picoseconds as printed or as plain defaults.
  localparam int T_DQSCK_MAX_PS = 3500;
  localparam int T_WTR_PS = 10000;
  localparam int T_RPST_PS = 5000;
  localparam int T_MRWGAP_PS = 7500;
  localparam int T_XP_PS = 7500;
  localparam int T_RCD_PS = 18000;
  localparam int T_MRD_PS = 14000;
  localparam int T_MRW_PS = 10000;

  function automatic int ru_nck(input int ps);
    int n;
    n = (ps + T_CK_PS - 1) / T_CK_PS;
    return (n < 1) ? 1 : n;
  endfunction

  function automatic int max_i(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int N_DQSCK = ru_nck(T_DQSCK_MAX_PS);
  localparam int N_RPST = T_RPST_PS / T_CK_PS;
  localparam int N_MRWGAP = max_i(ru_nck(T_MRWGAP_PS), MRW_FLOOR_NCK);

  // Least spacing in clocks between a leading command and the one that follows.
  localparam logic [GAP_W-1:0] GAP_MRR_ANY = GAP_W'(MRR_NCK);
  localparam logic [GAP_W-1:0] GAP_RD_MRR = GAP_W'(BL_HALF);
  localparam logic [GAP_W-1:0] GAP_WR_MRR = GAP_W'(WL_NCK + WR_EXTRA_NCK + BL_HALF + ru_nck(T_WTR_PS));
  localparam logic [GAP_W-1:0] GAP_PDX_MRR = GAP_W'(ru_nck(T_XP_PS) + ru_nck(T_RCD_PS));
  localparam logic [GAP_W-1:0] GAP_MRR_WR = GAP_W'(RL_NCK + N_DQSCK + BL_HALF - WL_NCK + WPRE_NCK + N_RPST);
  localparam logic [GAP_W-1:0] GAP_MRR_MRW = GAP_W'(RL_NCK + N_DQSCK + BL_HALF + MRR_MRW_EXTRA_NCK);
  localparam logic [GAP_W-1:0] GAP_RD_MRW = GAP_W'(RL_NCK + BL_HALF + N_DQSCK + N_RPST + N_MRWGAP);
  localparam logic [GAP_W-1:0] GAP_RDA_MRW = GAP_W'(RL_NCK + BL_HALF + N_DQSCK + N_RPST + N_MRWGAP
                                                    + NRTP_NCK - RTP_BASE_NCK);
  localparam logic [GAP_W-1:0] GAP_WR_MRW = GAP_W'(WL_NCK + WR_EXTRA_NCK + BL_HALF + N_MRWGAP);
  localparam logic [GAP_W-1:0] GAP_WRA_MRW = GAP_W'(WL_NCK + WR_EXTRA_NCK + BL_HALF + N_MRWGAP + NWR_NCK);
  localparam logic [GAP_W-1:0] GAP_MRD = GAP_W'(ru_nck(T_MRD_PS));
  localparam logic [GAP_W-1:0] GAP_MRW_MRW = GAP_W'(ru_nck(T_MRW_PS));

  // Device read path: address beat arrives one cycle after the command beat.
  localparam int MRR_PIPE = RL_NCK - 2;

  // Gap tracker indices, one per class of following command.
  localparam int G_ANY = 0;
  localparam int G_MRR = 1;
  localparam int G_RD = 2;
  localparam int G_WR = 3;
  localparam int G_MRW = 4;
  localparam int GAP_N = 5;

endpackage

// [hdl/mrat_if.sv]
// Command and data link between the controller end and the memory end.
`timescale 1ns/1ns
interface mrat_if;
  logic cke;
  logic cs;
  logic [5:0] ca;
  logic [7:0] dq_o;
  logic dq_oe;
  logic dqs_o;

  modport ctrl (
    output cke,
    output cs,
    output ca,
    input dq_o,
    input dq_oe,
    input dqs_o
  );

  modport dev (
    input cke,
    input cs,
    input ca,
    output dq_o,
    output dq_oe,
    output dqs_o
  );
endinterface

// [hdl/mrat_gap.sv]
// Down-counter that holds off one class of command until its least spacing has passed.
`timescale 1ns/1ns
module mrat_gap
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [mrat_pkg::GAP_W-1:0] load_val,
  output logic idle
);
  import mrat_pkg::*;

  logic [GAP_W-1:0] cnt_q;
  logic [GAP_W-1:0] cnt_d;
  wire [GAP_W-1:0] dec_val = (cnt_q != '0) ? cnt_q - 8'h01 : cnt_q;
  wire [GAP_W-1:0] ld_cnt = load_val - 8'h01;

  // A shorter new spacing never cuts an older, longer one short.
  assign cnt_d = (load && ld_cnt > dec_val) ? ld_cnt : dec_val;
  assign idle = (cnt_q == '0);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (ce)
      cnt_q <= cnt_d;
  end
endmodule

// [hdl/mrat_ctrl.sv]
// Controller end: issues mode register and data commands with the least spacing between them.
// Function
// (R01) Mode register read burst is always sixteen.
// (R02) Only deselects during the register read period.
// (R03) Read to register read: half burst.
// (R04) Write to register read: WL+1+BL/2+tWTR.
// (R05) Write-to-read time counts from burst end.
// (R06) Power-down exit adds exit and wake-up time.
// (R07) Register write taken with cke, select, lines.
// (R08) No register write inside write period.
// (R09) Writes to read-only registers change nothing.
// (R10) Register write keeps bank state unchanged.
// (R11) Register read keeps bank state unchanged.
// (R12) Register read to write: latency-based gap.
// (R13) Register read to register write: RL+DQSCK+BL/2+3.
// (R14) Reads to register write: latency plus eight.
// (R15) Writes to register write: latency plus eight.
// (R16) Mode-set delay after register write.
// (R17) Readback byte on low lane, four beats.
// (R18) Six-bit address selects one of sixty-four.
`timescale 1ns/1ns
module mrat_ctrl
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire mrat_pkg::mrat_op_t req_op,
  input wire logic [mrat_pkg::MA_W-1:0] req_addr,
  input wire logic [mrat_pkg::OP_W-1:0] req_data,
  output logic req_ack,
  output logic rd_valid,
  output logic [mrat_pkg::OP_W-1:0] rd_data,
  output logic pd_active,
  mrat_if.ctrl mem
);
  import mrat_pkg::*;

  typedef enum logic {C_IDLE, C_BEAT} mrat_cst_t;

  mrat_cst_t state_q;
  logic [1:0] beats_q;
  logic [3*CA_W-1:0] shift_q;
  logic cke_q;
  logic cs_q;
  logic [CA_W-1:0] ca_q;
  logic ack_q;
  logic rdv_q;
  logic [OP_W-1:0] rdd_q;
  logic [2:0] beat_q;
  logic gap_idle [GAP_N];
  logic [GAP_W-1:0] ld_val [GAP_N];

  // Command classes.
  wire is_mrr = req_op == OP_MRR;
  wire is_mrw = req_op == OP_MRW;
  wire is_rd = req_op == OP_RD || req_op == OP_RDF || req_op == OP_RDC;
  wire is_rda = req_op == OP_RDA;
  wire is_wr = req_op == OP_WR || req_op == OP_MWR || req_op == OP_WRF;
  wire is_wra = req_op == OP_WRA || req_op == OP_MWRA;
  wire is_pde = req_op == OP_PDE;
  wire is_pdx = req_op == OP_PDX;
  wire is_col_rd = is_rd || is_rda;
  wire is_col_wr = is_wr || is_wra;

  // The class of a request picks which tracker it must wait on.
  wire class_ok = (!is_mrr || gap_idle[G_MRR]) && (!is_col_rd || gap_idle[G_RD])
                  && (!is_col_wr || gap_idle[G_WR]) && (!is_mrw || gap_idle[G_MRW]);
  // Only power-down exit is legal while cke is low, and only then.
  wire pd_ok = cke_q ? !is_pdx : is_pdx;
  // (R02) deselect during register read
  wire allowed = gap_idle[G_ANY] && class_ok && pd_ok;
  wire issue = ce && state_q == C_IDLE && req_valid && !ack_q && allowed;

  // Encoding on the command lines for the first beat.
  wire [CA_W-1:0] cmd_code = is_mrr ? CMD_MRR : is_mrw ? CMD_MRW : req_op == OP_ACT ? CMD_ACT
                             : req_op == OP_PRE ? CMD_PRE : is_col_rd ? CMD_RD : is_col_wr ? CMD_WR
                             : CMD_OTHER;
  wire drives_cs = !is_pde && !is_pdx;
  // (R07) address then data on six lines
  wire [3*CA_W-1:0] beat_pay = {4'h0, req_data[7:6], req_data[5:0], req_addr};
  wire [1:0] beat_cnt = is_mrw ? 2'd3 : is_mrr ? 2'd1 : 2'd0;

  // Register read blocks everything for its period.
  assign ld_val[G_ANY] = is_mrr ? GAP_MRR_ANY : '0;

  // (R03) read to register read
  // (R04) write to register read
  // (R05) write-to-read from burst end
  // (R06) exit plus wake-up
  // (R16) mode-set delay to read
  assign ld_val[G_MRR] = is_col_rd ? GAP_RD_MRR : is_col_wr ? GAP_WR_MRR : is_mrw ? GAP_MRD
                         : is_pdx ? GAP_PDX_MRR : is_mrr ? GAP_MRR_ANY : '0;

  // (R16) mode-set delay to reads
  assign ld_val[G_RD] = is_mrr ? GAP_MRR_ANY : is_mrw ? GAP_MRD : '0;

  // (R12) register read to write
  // (R16) mode-set delay to writes
  assign ld_val[G_WR] = is_mrr ? GAP_MRR_WR : is_mrw ? GAP_MRD : '0;

  // (R08) write period between writes
  // (R13) register read to write
  // (R14) reads to register write
  // (R15) writes to register write
  assign ld_val[G_MRW] = is_mrr ? GAP_MRR_MRW : is_rd ? GAP_RD_MRW : is_rda ? GAP_RDA_MRW
                         : is_wr ? GAP_WR_MRW : is_wra ? GAP_WRA_MRW : is_mrw ? GAP_MRW_MRW : '0;

  for (genvar g = 0; g < GAP_N; g++)
  begin : g_gap
    mrat_gap u_gap (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .load(issue && ld_val[g] != '0),
      .load_val(ld_val[g]),
      .idle(gap_idle[g])
    );
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= C_IDLE;
      beats_q <= '0;
      shift_q <= '0;
    end
    else if (issue && beat_cnt != '0)
    begin
      state_q <= C_BEAT;
      beats_q <= beat_cnt;
      shift_q <= beat_pay;
    end
    else if (ce && state_q == C_BEAT)
    begin
      state_q <= (beats_q == 2'd1) ? C_IDLE : C_BEAT;
      beats_q <= beats_q - 2'd1;
      shift_q <= shift_q >> CA_W;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cs_q <= 1'b0;
      ca_q <= '0;
    end
    else if (issue)
    begin
      cs_q <= drives_cs;
      ca_q <= drives_cs ? cmd_code : '0;
    end
    else if (ce)
    begin
      cs_q <= 1'b0;
      ca_q <= (state_q == C_BEAT) ? shift_q[CA_W-1:0] : '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cke_q <= 1'b1;
    else if (issue && is_pde)
      cke_q <= 1'b0;
    else if (issue && is_pdx)
      cke_q <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else if (ce)
      ack_q <= issue;
  end

  // Beats are counted instead of watching the enable rise, because readbacks at the least spacing run back to back.
  wire burst_first = mem.dq_oe && beat_q == '0;
  wire [2:0] beat_nx = (mem.dq_oe && beat_q != 3'(BL_HALF - 1)) ? beat_q + 3'h1 : '0;

  // (R17) sample the low byte at burst start
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      beat_q <= '0;
      rdv_q <= 1'b0;
      rdd_q <= '0;
    end
    else if (ce)
    begin
      beat_q <= beat_nx;
      rdv_q <= burst_first;
      if (burst_first)
        rdd_q <= mem.dq_o;
    end
  end

  assign mem.cke = cke_q;
  assign mem.cs = cs_q;
  assign mem.ca = ca_q;
  assign req_ack = ack_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdd_q;
  assign pd_active = !cke_q;
endmodule

// [verif/mrat_checker.sv]
// Timing and burst checks on the link between the controller end and the memory end.
`timescale 1ns/1ns
module mrat_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs,
  input wire logic [5:0] ca,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic dqs_o
);
  import mrat_pkg::*;
  logic cke_q;
  logic [7:0] rd_q, wr_q, mrr_q, mrw_q, pdx_q;
  wire mrr_c = cke && cs && ca == CMD_MRR;
  wire mrw_c = cke && cs && ca == CMD_MRW;
  wire rd_c = cke && cs && ca == CMD_RD;
  wire wr_c = cke && cs && ca == CMD_WR;
  wire pdx_c = cke && !cke_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Ages stop at FF, so a command long past never wraps round into a short gap.
  function automatic logic [7:0] age(input logic hit, input logic [7:0] a);
    return hit ? 8'h01 : a + {7'h00, a != 8'hFF};
  endfunction
  always_ff @(posedge clock)
  begin
    cke_q <= cke || !rst_n;
    rd_q <= rst_n ? age(rd_c, rd_q) : 8'hFF;
    wr_q <= rst_n ? age(wr_c, wr_q) : 8'hFF;
    mrr_q <= rst_n ? age(mrr_c, mrr_q) : 8'hFF;
    mrw_q <= rst_n ? age(mrw_c, mrw_q) : 8'hFF;
    pdx_q <= rst_n ? age(pdx_c, pdx_q) : 8'hFF;
  end
  a_mrr_burst_len: assert property (mrr_c |-> ##14 dq_oe [*8])
    else $error("readback burst is not eight clocks long");
  a_mrr_strobe_toggle: assert property (mrr_c |-> ##14 dqs_o ##1 !dqs_o ##1 dqs_o ##1 !dqs_o)
    else $error("readback strobe does not toggle");
  a_mrr_only_deselect: assert property (mrr_c |=> !cs [*7])
    else $error("command issued inside register read period");
  a_rd_mrr_gap: assert property (mrr_c |-> rd_q >= 8)
    else $error("register read too soon after read");
  a_wr_mrr_gap: assert property (mrr_c |-> wr_q >= 18)
    else $error("register read too soon after write");
  a_pdx_mrr_gap: assert property (mrr_c |-> pdx_q >= 3)
    else $error("register read too soon after wake-up");
  a_mrw_period: assert property (mrw_c |=> !cs [*3])
    else $error("command issued inside register write beats");
  a_mrr_wr_gap: assert property (wr_c |-> mrr_q >= 17)
    else $error("write too soon after register read");
  a_mrr_mrw_gap: assert property (mrw_c |-> mrr_q >= 26)
    else $error("register write too soon after register read");
  a_rd_mrw_gap: assert property (mrw_c |-> rd_q >= 31)
    else $error("register write too soon after read");
  a_wr_mrw_gap: assert property (mrw_c |-> wr_q >= 25)
    else $error("register write too soon after write");
  a_mrw_settle: assert property ((mrr_c || rd_c || wr_c) |-> mrw_q >= 2)
    else $error("command too soon after register write");
  c_mrr: cover property (mrr_c);
  c_mrw: cover property (mrw_c);
  c_wake: cover property (pdx_c);
endmodule

// [verif/tb_top.sv]
// Testbench joining the controller end to the memory end and checking readback and spacing.
`timescale 1ns/1ns
module tb_top;
  import mrat_pkg::*;
  logic clock, rst_n, ce, req_valid, req_ack, rd_valid, pd_active, banks_active, mrw_done;
  mrat_op_t req_op;
  logic [5:0] req_addr, mrw_addr;
  logic [7:0] req_data, rd_data, mrw_data;
  int n_fail, samples_checked, t_ack;
  int cyc = 0;
  // Rounded clock counts of the timing values at a 10 ns clock.
  localparam int DQSCK_N = 1;
  localparam int WTR_N = 1;
  localparam int RD_MRW = RL_NCK + BL_HALF + DQSCK_N + 8;
  localparam int WR_MRW = WL_NCK + 1 + BL_HALF + 8;
  mrat_if link ();
  mrat_ctrl mrat_ctrl_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ack(req_ack),
    .rd_valid(rd_valid), .rd_data(rd_data), .pd_active(pd_active), .mem(link.ctrl));
  mrat_dev mrat_dev_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .mem(link.dev),
    .banks_active(banks_active), .mrw_done(mrw_done), .mrw_addr(mrw_addr), .mrw_data(mrw_data));
  mrat_checker mrat_checker_inst (.clock(clock), .rst_n(rst_n), .cke(link.cke), .cs(link.cs),
    .ca(link.ca), .dq_o(link.dq_o), .dq_oe(link.dq_oe), .dqs_o(link.dqs_o));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Holds the request until the acknowledge is seen; with keep set the next call takes over the request lines.
  task automatic issue(input mrat_op_t op, input logic [5:0] a, input logic [7:0] d, input logic keep);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    @(posedge clock);
    #1;
    while (req_ack !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(8'h01, {7'h00, req_ack});
    t_ack = cyc;
    if (!keep)
    begin
      @(posedge clock);
      req_valid <= 1'b0;
    end
  endtask
  task automatic gap(input mrat_op_t a, input mrat_op_t b, input int min);
    int t0;
    issue(a, 6'h01, 8'h00, 1'b1);
    t0 = t_ack;
    issue(b, 6'h01, 8'h3C, 1'b0);
    samples_checked++;
    if (t_ack - t0 < min)
    begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, min, t_ack - t0);
    end
  endtask
  task automatic mrw(input logic [5:0] a, input logic [7:0] d, input logic done);
    issue(OP_MRW, a, d, 1'b0);
    repeat (3) @(posedge clock);
    #1;
    chk({7'h00, done}, {7'h00, mrw_done});
    chk({2'h0, a}, {2'h0, mrw_addr});
    if (done)
      chk(d, mrw_data);
  endtask
  task automatic mrr(input logic [5:0] a, input logic [7:0] exp);
    issue(OP_MRR, a, 8'h00, 1'b0);
    repeat (13) @(posedge clock);
    #1;
    chk(8'h01, {7'h00, link.dq_oe});
    chk(exp, link.dq_o);
    @(posedge clock);
    #1;
    chk(exp, link.dq_o);
    chk(8'h01, {7'h00, rd_valid});
    chk(exp, rd_data);
  endtask
  task automatic t_write_read;
    int t0;
    mrw(6'h01, 8'hA5, 1'b1);
    mrw(6'h3F, 8'h5C, 1'b1);
    mrr(6'h01, 8'hA5);
    mrr(6'h3F, 8'h5C);
    // Two readbacks at the least spacing give bursts back to back; each byte must still be caught.
    issue(OP_MRR, 6'h01, 8'h00, 1'b1);
    t0 = t_ack;
    issue(OP_MRR, 6'h3F, 8'h00, 1'b0);
    while (cyc < t0 + 15)
    begin
      @(posedge clock);
      #1;
    end
    chk(8'h01, {7'h00, rd_valid});
    chk(8'hA5, rd_data);
    while (cyc < t0 + 23)
    begin
      @(posedge clock);
      #1;
    end
    chk(8'h01, {7'h00, rd_valid});
    chk(8'h5C, rd_data);
  endtask
  task automatic t_read_only;
    mrw(6'h00, 8'h77, 1'b0);
    mrw(6'h08, 8'h77, 1'b0);
    mrw(6'h09, 8'h66, 1'b1);
    mrr(6'h00, 8'h00);
    mrr(6'h08, 8'h00);
    mrr(6'h09, 8'h66);
  endtask
  task automatic t_banks;
    issue(OP_ACT, 6'h00, 8'h00, 1'b0);
    mrw(6'h02, 8'h11, 1'b1);
    chk(8'h01, {7'h00, banks_active});
    mrr(6'h02, 8'h11);
    chk(8'h01, {7'h00, banks_active});
    issue(OP_PRE, 6'h00, 8'h00, 1'b0);
    mrr(6'h02, 8'h11);
    mrw(6'h02, 8'h22, 1'b1);
    chk(8'h00, {7'h00, banks_active});
  endtask
  task automatic t_read_gaps;
    gap(OP_RD, OP_MRR, BL_HALF);
    gap(OP_RDA, OP_MRR, BL_HALF);
    gap(OP_RD, OP_MRW, RD_MRW);
    gap(OP_RDA, OP_MRW, RD_MRW + NRTP_NCK - 8);
    gap(OP_RDF, OP_MRW, RD_MRW);
    gap(OP_RDC, OP_MRW, RD_MRW);
  endtask
  task automatic t_write_gaps;
    gap(OP_WR, OP_MRR, WL_NCK + 1 + BL_HALF + WTR_N);
    gap(OP_MWRA, OP_MRR, WL_NCK + 1 + BL_HALF + WTR_N);
    gap(OP_WR, OP_MRW, WR_MRW);
    gap(OP_MWR, OP_MRW, WR_MRW);
    gap(OP_WRF, OP_MRW, WR_MRW);
    gap(OP_WRA, OP_MRW, WR_MRW + NWR_NCK);
  endtask
  task automatic t_mrr_gaps;
    gap(OP_MRR, OP_MRR, MRR_NCK);
    gap(OP_MRR, OP_RD, MRR_NCK);
    gap(OP_MRR, OP_WRA, RL_NCK + DQSCK_N + BL_HALF - WL_NCK + WPRE_NCK);
    gap(OP_MRR, OP_MRW, RL_NCK + DQSCK_N + BL_HALF + 3);
    gap(OP_MRW, OP_MRR, 2);
    gap(OP_MRW, OP_WR, 2);
    gap(OP_MRW, OP_MRW, 4);
  endtask
  task automatic t_power_down;
    issue(OP_PDE, 6'h00, 8'h00, 1'b0);
    @(posedge clock);
    #1;
    chk(8'h01, {7'h00, pd_active});
    gap(OP_PDX, OP_MRR, 3);
    chk(8'h00, {7'h00, pd_active});
  endtask
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_op = OP_RD;
    req_addr = 6'h00;
    req_data = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_write_read();
    t_read_only();
    t_banks();
    t_read_gaps();
    t_write_gaps();
    t_mrr_gaps();
    t_power_down();
    end_of_test();
  end
  // The whole sequence needs well under a thousand clocks; ten thousand means a hang.
  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule
